// [design/waveform_average_envelope_acquire.sv]
/*
 * Acquisition combiner: plain replacement, running average and min/max
 * envelope of successive sample records, with restart and mode interlocks.
 * Assumes samples arrive on core_clk_i from same-clock logic, one per cycle
 * at most, with sof marking the first sample of each record.
 */
// Added by the designer: the placing of the registers and register access over Avalon-MM.
//
// Contract
// - Plain mode passes each new record straight to the display output.
// - Averaging count is a power of two from 2 to 256.
// - Listed setting changes abandon averaging and start a fresh sequence.
// - Entering scrolling while averaging switches acquisition to plain mode.
// - Selecting averaging while scrolling sets trigger to normal, ending scrolling.
// - Averaging suppresses delta-delayed sweep display unless a reference shows.
// - Averaging raises the no-delta-delay message flag.
// - Envelope presents accumulated min/max after the selected record count.
// - Each sample is compared with stored min and max at its position.
// - Higher sample replaces maximum; lower sample replaces minimum.
// - Sample between stored min and max leaves both unchanged.
// - Envelope count is 1 to 256 in powers of two, or unlimited.
// - Unlimited envelope accumulates and displays every record without end.
// - Envelope restarts like averaging, but not on vertical position change.
// - Unlimited envelope ignores delay time changes.
// - Envelope restart drops display, clears stored extremes, begins anew.
// - Scrolling is only possible in plain and envelope modes.
// - Envelope with scrolling uses a sequence length of one record.
// - Envelope with scrolling enables the fast envelope sampling flag.
// - Equivalent-time sampling is blocked while envelope mode is selected.
// - Auto trigger with slowest timebase range enters scrolling automatically.
`timescale 1ns/100ps

module waveform_average_envelope_acquire
    import acq_pkg::*;
#(
    parameter int              REC_LEN    = 1024,
    parameter logic [TB_W-1:0] ROLL_TB_LO = 5'h18,
    parameter logic [TB_W-1:0] ROLL_TB_HI = 5'h1C
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // Avalon-MM register slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Sample stream
    input  wire samp_in_t    samp_i,
    output samp_out_t        disp_o,
    // Display and sampling control
    output logic             delta_b_show_o,
    output logic             no_delta_msg_o,
    output logic             scroll_o,
    output logic             env_fast_o,
    output logic             equivalent_time_sampling_o,
    output logic      [1:0]  trig_mode_o
);

    localparam int PW = $clog2(REC_LEN);
    localparam logic [PW-1:0] POS_LAST = PW'(REC_LEN - 1);

    // ========================================================================
    // Functions
    // ========================================================================
    function automatic logic roll_cond(input trig_mode_t t, input logic ha,
                                       input logic [TB_W-1:0] tb);
        roll_cond = (t == TRG_AUTO) && ha && (tb >= ROLL_TB_LO) && (tb <= ROLL_TB_HI);
    endfunction
    function automatic logic [3:0] flog2(input logic [9:0] v);
        flog2 = 4'h0;
        for (int i = 1; i < 10; i++) begin
            if (v[i]) begin
                flog2 = 4'(i);
            end
        end
    endfunction
    function automatic logic [CHG_W-1:0] restart_mask(input acq_mode_t m, input logic unl);
        restart_mask = {CHG_W{1'b1}};
        if (m == ACQ_ENV) begin
            restart_mask[CHG_VPOS] = 1'b0;
            if (unl) begin
                restart_mask[CHG_DLY_TIME] = 1'b0;
            end
        end
    endfunction

    // ========================================================================
    // Register state
    // ========================================================================
    acq_mode_t         mode_ff;
    trig_mode_t        trig_ff;
    logic [3:0]        avg_log_ff;
    logic [3:0]        env_code_ff;
    logic [TB_W-1:0]   tb_ff;
    logic              ha_ff;
    logic              ref_ff;
    logic              equivalent_time_sampling_req_ff;
    logic              scroll_ff;
    logic              wait_ff;
    logic [31:0]       rdata_ff;
    logic              done_ff;
    logic              skip_ff;
    logic [8:0]        env_rec_ff;
    logic [8:0]        avg_rec_ff;
    logic [PW-1:0]     pos_ff;
    samp_out_t         disp_ff;
    logic [SAMP_W-1:0] max_mem [REC_LEN];
    logic [SAMP_W-1:0] min_mem [REC_LEN];
    logic [AVG_W-1:0]  avg_mem [REC_LEN];
    logic [31:0]       bmask;
    logic [31:0]       ctrl_rd;
    logic [31:0]       stat_rd;
    logic [31:0]       merged;
    logic              ctrl_wr;
    logic              chg_wr;
    logic              stat_wr;
    acq_mode_t         nxt_mode;
    trig_mode_t        nxt_trig;
    logic [3:0]        nxt_avg_log;
    logic [3:0]        nxt_env_code;
    logic              unlimited;
    logic              restart;
    assign bmask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign ctrl_wr = avs_write_i && !wait_ff && (avs_address_i == REG_CTRL);
    assign chg_wr  = avs_write_i && !wait_ff && (avs_address_i == REG_CHANGE);
    assign stat_wr = avs_write_i && !wait_ff && (avs_address_i == REG_STATUS);
    assign merged  = (ctrl_rd & ~bmask) | (avs_writedata_i & bmask);
    assign unlimited = (env_code_ff == ENV_CODE_UNLIM) && !scroll_ff;
    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[CTRL_MODE_LSB +: 2] = mode_ff;
        ctrl_rd[CTRL_AVG_LSB +: 4]  = avg_log_ff;
        ctrl_rd[CTRL_ENV_LSB +: 4]  = env_code_ff;
        ctrl_rd[CTRL_EQUIVALENT_TIME_SAMPLING_BIT]     = equivalent_time_sampling_req_ff;
        ctrl_rd[CTRL_REF_BIT]       = ref_ff;
        ctrl_rd[CTRL_TRIG_LSB +: 2] = trig_ff;
        ctrl_rd[CTRL_TB_LSB +: TB_W] = tb_ff;
        ctrl_rd[CTRL_HA_BIT]        = ha_ff;
    end
    always_comb begin
        stat_rd = 32'h0000_0000;
        stat_rd[STAT_MODE_LSB +: 2] = mode_ff;
        stat_rd[STAT_SCROLL]        = scroll_ff;
        stat_rd[STAT_EQUIVALENT_TIME_SAMPLING]         = equivalent_time_sampling_o;
        stat_rd[STAT_MSG]           = no_delta_msg_o;
        stat_rd[STAT_SKIP]          = skip_ff;
        stat_rd[STAT_ENV_LSB +: 9]  = env_rec_ff;
        stat_rd[STAT_AVG_LSB +: 9]  = avg_rec_ff;
        stat_rd[STAT_DONE]          = done_ff;
    end

    // ========================================================================
    // Control write decode with mode interlocks
    // ========================================================================
    always_comb begin
        nxt_mode     = acq_mode_t'(merged[CTRL_MODE_LSB +: 2]);
        nxt_trig     = trig_mode_t'(merged[CTRL_TRIG_LSB +: 2]);
        nxt_avg_log  = merged[CTRL_AVG_LSB +: 4];
        nxt_env_code = merged[CTRL_ENV_LSB +: 4];
        if (nxt_mode == 2'b10) begin
            nxt_mode = ACQ_NORMAL;
        end
        if (nxt_trig == 2'b10) begin
            nxt_trig = TRG_NORMAL;
        end
        if (nxt_avg_log < AVG_LOG_MIN) begin
            nxt_avg_log = AVG_LOG_MIN;
        end else if (nxt_avg_log > AVG_LOG_MAX) begin
            nxt_avg_log = AVG_LOG_MAX;
        end
        if (nxt_env_code > ENV_CODE_UNLIM) begin
            nxt_env_code = ENV_CODE_UNLIM;
        end
        if ((nxt_mode == ACQ_AVG) && (mode_ff != ACQ_AVG) && scroll_ff) begin
            nxt_trig = TRG_NORMAL;
        end else if ((nxt_mode == ACQ_AVG) &&
                     roll_cond(nxt_trig, merged[CTRL_HA_BIT], merged[CTRL_TB_LSB +: TB_W])) begin
            nxt_mode = ACQ_NORMAL;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            mode_ff      <= ACQ_NORMAL;
            trig_ff      <= TRG_AUTO;
            avg_log_ff   <= RST_AVG_LOG;
            env_code_ff  <= RST_ENV_CODE;
            tb_ff        <= '0;
            ha_ff        <= 1'b1;
            ref_ff       <= 1'b0;
            equivalent_time_sampling_req_ff <= 1'b0;
        end else if (ctrl_wr) begin
            mode_ff      <= nxt_mode;
            trig_ff      <= nxt_trig;
            avg_log_ff   <= nxt_avg_log;
            env_code_ff  <= nxt_env_code;
            tb_ff        <= merged[CTRL_TB_LSB +: TB_W];
            ha_ff        <= merged[CTRL_HA_BIT];
            ref_ff       <= merged[CTRL_REF_BIT];
            equivalent_time_sampling_req_ff <= merged[CTRL_EQUIVALENT_TIME_SAMPLING_BIT];
        end
    end

    // ========================================================================
    // Avalon-MM handshake: one wait cycle, then the access completes
    // ========================================================================
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if ((avs_read_i || avs_write_i) && wait_ff) begin
            wait_ff <= 1'b0;
            if (avs_read_i && (avs_address_i == REG_CTRL)) begin
                rdata_ff <= ctrl_rd;
            end else if (avs_read_i && (avs_address_i == REG_STATUS)) begin
                rdata_ff <= stat_rd;
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end else begin
            wait_ff <= 1'b1;
        end
    end
    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rdata_ff;

    // ========================================================================
    // Mode derived outputs
    // ========================================================================
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            scroll_ff      <= 1'b0;
            delta_b_show_o <= 1'b1;
            no_delta_msg_o <= 1'b0;
            env_fast_o     <= 1'b0;
            equivalent_time_sampling_o        <= 1'b0;
        end else begin
            scroll_ff      <= roll_cond(trig_ff, ha_ff, tb_ff) &&
                              (mode_ff != ACQ_AVG);
            delta_b_show_o <= (mode_ff != ACQ_AVG) || ref_ff;
            no_delta_msg_o <= (mode_ff == ACQ_AVG);
            env_fast_o     <= (mode_ff == ACQ_ENV) && roll_cond(trig_ff, ha_ff, tb_ff);
            equivalent_time_sampling_o        <= equivalent_time_sampling_req_ff && (mode_ff != ACQ_ENV);
        end
    end
    assign scroll_o    = scroll_ff;
    assign trig_mode_o = trig_ff;

    // ========================================================================
    // Sequence restart and record bookkeeping
    // ========================================================================
    logic [CHG_W-1:0]  chg_bits;
    logic              take;
    logic              last;
    logic [PW-1:0]     pos_cur;
    logic [8:0]        env_n;
    logic              env_done;
    logic [9:0]        avg_r;
    logic [9:0]        avg_n;
    logic [3:0]        avg_s;
    assign chg_bits = avs_writedata_i[CHG_W-1:0] & bmask[CHG_W-1:0];
    assign restart  = ctrl_wr ||
                      (chg_wr && |(chg_bits & restart_mask(mode_ff, unlimited)));
    assign take     = samp_i.valid && (!skip_ff || samp_i.sof) && !restart;
    assign pos_cur  = samp_i.sof ? '0 : pos_ff;
    assign last     = (pos_cur == POS_LAST);
    assign env_n    = scroll_ff ? 9'h001 :
                      (env_code_ff == ENV_CODE_MAX) ? REC_CNT_MAX :
                      9'(10'h001 << env_code_ff[2:0]);
    assign env_done = !unlimited && ((10'(env_rec_ff) + 10'h001) == 10'(env_n));
    assign avg_r    = 10'(avg_rec_ff) + 10'h001;
    assign avg_n    = 10'h001 << avg_log_ff;
    assign avg_s    = (flog2(avg_r) < avg_log_ff) ? flog2(avg_r) : avg_log_ff;
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            skip_ff <= 1'b1;
        end else if (restart) begin
            skip_ff <= 1'b1;
        end else if (samp_i.valid && samp_i.sof) begin
            skip_ff <= 1'b0;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pos_ff <= '0;
        end else if (take) begin
            pos_ff <= last ? '0 : PW'(pos_cur + 1'b1);
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            env_rec_ff <= 9'h000;
            avg_rec_ff <= 9'h000;
        end else if (restart) begin
            env_rec_ff <= 9'h000;
            avg_rec_ff <= 9'h000;
        end else if (take && last) begin
            if (env_done) begin
                env_rec_ff <= 9'h000;
            end else if (env_rec_ff != REC_CNT_MAX) begin
                env_rec_ff <= env_rec_ff + 9'h001;
            end
            if (avg_rec_ff != REC_CNT_MAX) begin
                avg_rec_ff <= avg_rec_ff + 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            done_ff <= 1'b0;
        end else if (take && last &&
                     (((mode_ff == ACQ_ENV) && env_done) ||
                      ((mode_ff == ACQ_AVG) && (avg_r == avg_n)))) begin
            done_ff <= 1'b1;
        end else if (stat_wr && avs_writedata_i[STAT_DONE] && avs_byteenable_i[3]) begin
            done_ff <= 1'b0;
        end
    end

    // ========================================================================
    // Per-position datapath
    // ========================================================================
    logic [SAMP_W-1:0]  x;
    logic [SAMP_W-1:0]  nmax;
    logic [SAMP_W-1:0]  nmin;
    logic [AVG_W-1:0]   old_avg;
    logic signed [AVG_W:0] diff;
    logic [AVG_W-1:0]   navg;
    logic               first_env;

    assign x         = samp_i.data;
    assign first_env = (env_rec_ff == 9'h000);
    assign old_avg   = avg_mem[pos_cur];
    assign diff      = $signed({1'b0, x, {FRAC_W{1'b0}}}) - $signed({1'b0, old_avg});
    assign navg      = (avg_rec_ff == 9'h000) ? {x, {FRAC_W{1'b0}}} :
                       AVG_W'($signed({1'b0, old_avg}) + (diff >>> avg_s));
    always_comb begin
        nmax = max_mem[pos_cur];
        nmin = min_mem[pos_cur];
        if (first_env) begin
            nmax = x;
            nmin = x;
        end else begin
            if (x > nmax) begin
                nmax = x;
            end
            if (x < nmin) begin
                nmin = x;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (take && (mode_ff == ACQ_ENV)) begin
            max_mem[pos_cur] <= nmax;
            min_mem[pos_cur] <= nmin;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (take && (mode_ff == ACQ_AVG)) begin
            avg_mem[pos_cur] <= navg;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            disp_ff <= '0;
        end else begin
            disp_ff.last <= last;
            if (!take) begin
                disp_ff.valid <= 1'b0;
            end else if (mode_ff == ACQ_AVG) begin
                disp_ff.valid <= 1'b1;
                disp_ff.data  <= navg[AVG_W-1:FRAC_W];
                disp_ff.vmin  <= navg[AVG_W-1:FRAC_W];
                disp_ff.vmax  <= navg[AVG_W-1:FRAC_W];
            end else if (mode_ff == ACQ_ENV) begin
                disp_ff.valid <= env_done || unlimited;
                disp_ff.data  <= x;
                disp_ff.vmin  <= nmin;
                disp_ff.vmax  <= nmax;
            end else begin
                disp_ff.valid <= 1'b1;
                disp_ff.data  <= x;
                disp_ff.vmin  <= x;
                disp_ff.vmax  <= x;
            end
        end
    end

    assign disp_o = disp_ff;

endmodule

// [design/acq_pkg.sv]
/*
 * Shared constants and types for the waveform acquisition combiner: register
 * offsets, field positions, reset values, mode encodings and stream carriers.
 * Assumes a single clock domain and a 32-bit Avalon-MM register bus.
 */
package acq_pkg;

    // ========================================================================
    // Widths and register offsets
    // ========================================================================
    localparam int         SAMP_W     = 8;
    localparam int         FRAC_W     = 8;
    localparam int         AVG_W      = SAMP_W + FRAC_W;
    localparam int         TB_W       = 5;
    localparam int         CHG_W      = 9;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CHANGE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // ========================================================================
    // Control register fields
    // ========================================================================
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_AVG_LSB   = 4;
    localparam int CTRL_ENV_LSB   = 8;
    localparam int CTRL_EQUIVALENT_TIME_SAMPLING_BIT = 13;
    localparam int CTRL_REF_BIT   = 14;
    localparam int CTRL_TRIG_LSB  = 16;
    localparam int CTRL_TB_LSB    = 20;
    localparam int CTRL_HA_BIT    = 25;

    // ========================================================================
    // Setting change event bits
    // ========================================================================
    localparam int CHG_VMODE     = 0;
    localparam int CHG_HMODE     = 1;
    localparam int CHG_GAIN      = 2;
    localparam int CHG_VPOS      = 3;
    localparam int CHG_COUPLING  = 4;
    localparam int CHG_TRIG      = 5;
    localparam int CHG_DLY_TIME  = 6;
    localparam int CHG_DLY_EVENT = 7;
    localparam int CHG_MENU_OFF  = 8;

    // ========================================================================
    // Status register fields
    // ========================================================================
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_SCROLL    = 2;
    localparam int STAT_EQUIVALENT_TIME_SAMPLING     = 3;
    localparam int STAT_MSG       = 4;
    localparam int STAT_SKIP      = 5;
    localparam int STAT_ENV_LSB   = 8;
    localparam int STAT_AVG_LSB   = 20;
    localparam int STAT_DONE      = 31;

    // ========================================================================
    // Encodings and reset values
    // ========================================================================
    localparam logic [3:0] AVG_LOG_MIN     = 4'h1;
    localparam logic [3:0] AVG_LOG_MAX     = 4'h8;
    localparam logic [3:0] ENV_CODE_MAX    = 4'h8;
    localparam logic [3:0] ENV_CODE_UNLIM  = 4'h9;
    localparam logic [3:0] RST_AVG_LOG     = 4'h1;
    localparam logic [3:0] RST_ENV_CODE    = 4'h0;
    localparam logic [8:0] REC_CNT_MAX     = 9'h100;

    typedef enum logic [1:0] {
        ACQ_NORMAL = 2'b00,
        ACQ_AVG    = 2'b01,
        ACQ_ENV    = 2'b11
    } acq_mode_t;

    typedef enum logic [1:0] {
        TRG_NORMAL     = 2'b00,
        TRG_AUTO       = 2'b01,
        TRG_AUTO_LEVEL = 2'b11
    } trig_mode_t;

    // ========================================================================
    // Stream carriers
    // ========================================================================
    typedef struct packed {
        logic              valid;
        logic              sof;
        logic [SAMP_W-1:0] data;
    } samp_in_t;

    typedef struct packed {
        logic              valid;
        logic              last;
        logic [SAMP_W-1:0] data;
        logic [SAMP_W-1:0] vmin;
        logic [SAMP_W-1:0] vmax;
    } samp_out_t;

endpackage

// [test/acq_checker.sv]
/* Port checker for the acquisition combiner.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module acq_checker
    import acq_pkg::*;
(
    // Watched ports
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic       avs_read_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    input wire samp_in_t   samp_i,
    input wire samp_out_t  disp_o,
    input wire logic       delta_b_show_o,
    input wire logic       no_delta_msg_o,
    input wire logic       scroll_o,
    input wire logic       env_fast_o,
    input wire logic       equivalent_time_sampling_o,
    input wire logic [1:0] trig_mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ========================================================================
    // Assertions
    // ========================================================================
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus answer late");
    answer_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("bus answer too long");
    disp_latency_a: assert property (disp_o.valid |-> $past(samp_i.valid))
        else $error("output without sample");
    avg_noscroll_a: assert property (no_delta_msg_o && $past(no_delta_msg_o)
        && $past(no_delta_msg_o, 2) |-> !scroll_o) else $error("scroll in averaging");
    scroll_auto_a: assert property (scroll_o |-> $past(trig_mode_o) == 2'b01)
        else $error("scroll without auto trigger");
    fast_scroll_a: assert property (env_fast_o |-> scroll_o)
        else $error("fast envelope without scroll");
    fast_norep_a: assert property (env_fast_o |-> !equivalent_time_sampling_o)
        else $error("repetitive with envelope");
    hide_delta_a: assert property (!delta_b_show_o |-> no_delta_msg_o
        || $past(no_delta_msg_o)) else $error("delta hidden outside averaging");
endmodule
bind waveform_average_envelope_acquire acq_checker u_chk (.*);

// [test/digitizer_model.sv]
/* Digitizer model: sends one record of ramp samples per go pulse.
   Assumes the combiner's clock; data churns between records. */
`timescale 1ns/100ps
module digitizer_model
    import acq_pkg::*;
#(
    parameter int REC_LEN = 8
) (
    // Clock and control
    input  wire logic              core_clk_i,
    input  wire logic              go_i,
    input  wire logic [SAMP_W-1:0] base_i,
    // Sample stream
    output samp_in_t               samp_o
);
    logic              busy_ff = 1'b0;
    logic [7:0]        idx_ff  = 8'h00;
    logic [SAMP_W-1:0] base_ff = 8'h00;
    logic [SAMP_W-1:0] junk_ff = 8'h5A;
    always_ff @(posedge core_clk_i) begin
        junk_ff <= ~junk_ff;
        if (!busy_ff && go_i) begin
            busy_ff <= 1'b1;
            idx_ff  <= 8'h00;
            base_ff <= base_i;
        end else if (busy_ff) begin
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff == 8'(REC_LEN - 1)) busy_ff <= 1'b0;
        end
    end
    assign samp_o.valid = busy_ff;
    assign samp_o.sof   = busy_ff && (idx_ff == 8'h00);
    assign samp_o.data  = busy_ff ? base_ff + idx_ff : junk_ff;
endmodule

// [test/waveform_average_envelope_acquire_test.sv]
/* Self-checking bench for the acquisition combiner.
   Assumes the digitizer model and the bound checker. */
`timescale 1ns/100ps
module waveform_average_envelope_acquire_test
    import acq_pkg::*;
;
    typedef struct packed { logic [31:0] ctrl; logic [8:0] exp; } row_t;
    localparam int RL = 8;
    logic        core_clk_i = 1'b0;
    logic        rstn_i, avs_read_i, avs_write_i, waitreq, go, msg, show, rep, scr, fast;
    logic [3:0]  avs_address_i;
    logic [31:0] avs_writedata_i, rdata, rd;
    logic [1:0]  trig;
    logic [7:0]  base;
    samp_in_t    samp;
    samp_out_t   disp, got[$];
    int          miscompares, comparisons;
    row_t rows [9] = '{'{32'h0, 9'h020}, '{32'h31, 9'h0C0}, '{32'h6031, 9'h0F0},
        '{32'h2203, 9'h1A0}, '{32'h03810000, 9'h029}, '{32'h03810031, 9'h0C0},
        '{32'h03810031, 9'h029}, '{32'h03810303, 9'h1AD}, '{32'h03D10000, 9'h021}};
    waveform_average_envelope_acquire #(.REC_LEN(RL)) u_dut (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .samp_i(samp), .disp_o(disp), .delta_b_show_o(show), .no_delta_msg_o(msg),
        .scroll_o(scr), .env_fast_o(fast), .equivalent_time_sampling_o(rep), .trig_mode_o(trig));
    digitizer_model #(.REC_LEN(RL)) u_dig (.core_clk_i(core_clk_i), .go_i(go),
        .base_i(base), .samp_o(samp));
    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (disp.valid === 1'b1) got.push_back(disp);
    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge core_clk_i);
        while (waitreq !== 1'b0) @(posedge core_clk_i);
        rd = rdata;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic send(input logic [7:0] b);
        base <= b;
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        repeat (RL + 3) @(posedge core_clk_i);
    endtask
    task automatic chk_out(input logic [7:0] lo, input logic [7:0] hi, input logic env);
        check(got.size(), RL);
        foreach (got[i]) begin
            if (env) check({got[i].vmin, got[i].vmax}, {lo + 8'(i), hi + 8'(i)});
            else check(got[i].data, lo + 8'(i));
            check(got[i].last, i == RL - 1);
        end
        got.delete();
    endtask
    task automatic wrap_up();
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ========================================================================
    // Sequence
    // ========================================================================
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
    initial begin
        {rstn_i, avs_read_i, avs_write_i, go, base, avs_address_i} = '0;
        avs_writedata_i = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        @(posedge core_clk_i);
        check({msg, show, rep, scr, fast, trig}, 32'h21);
        foreach (rows[i]) begin
            bus(1'b1, REG_CTRL, rows[i].ctrl);
            repeat (3) @(posedge core_clk_i);
            bus(1'b0, REG_STATUS, 32'h0);
            check({rd[1:0], msg, show, rep, scr, fast, trig}, rows[i].exp);
        end
        bus(1'b1, REG_CTRL, 32'h0);
        send(8'h10);
        chk_out(8'h10, 8'h10, 1'b0);
        bus(1'b1, REG_CTRL, 32'h11);
        send(8'h10);
        send(8'h20);
        got.delete();
        send(8'h20);
        chk_out(8'h1C, 8'h1C, 1'b0);
        bus(1'b1, REG_CHANGE, 32'h1);
        got.delete();
        send(8'h40);
        chk_out(8'h40, 8'h40, 1'b0);
        bus(1'b1, REG_CTRL, 32'h203);
        send(8'h10);
        send(8'h20);
        bus(1'b1, REG_CHANGE, 32'h4);
        send(8'h30);
        send(8'h38);
        bus(1'b1, REG_CHANGE, 32'h8);
        send(8'h34);
        send(8'h32);
        chk_out(8'h30, 8'h38, 1'b1);
        bus(1'b1, REG_CTRL, 32'h903);
        send(8'h50);
        chk_out(8'h50, 8'h50, 1'b1);
        bus(1'b1, REG_CHANGE, 32'h40);
        send(8'h48);
        chk_out(8'h48, 8'h50, 1'b1);
        rstn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        @(posedge core_clk_i);
        check({msg, show, rep, scr, fast, trig}, 32'h21);
        bus(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h0201_0010);
        bus(1'b0, 4'hC, 32'h0);
        check(rd, 32'h0);
        wrap_up();
    end
endmodule
